/* File: verilog/arb_result_bank_map.vh */
// Address map, field layout and reset values of the result register bank.
// Included by the bank's modules; holds definitions only.
`ifndef ARB_RESULT_BANK_MAP_VH
`define ARB_RESULT_BANK_MAP_VH

// Register indices; the byte address is four times the index.
`define ARB_IDX_CH3_LOW    10'h126
`define ARB_IDX_CH3_HIGH   10'h127
`define ARB_IDX_CH4_LOW    10'h128
`define ARB_IDX_CH4_HIGH   10'h129
`define ARB_IDX_CH5_LOW    10'h12A
`define ARB_IDX_CH5_HIGH   10'h12B
`define ARB_IDX_CH6_LOW    10'h12C
`define ARB_IDX_CH6_HIGH   10'h12D
`define ARB_IDX_CH7_LOW    10'h12E
`define ARB_IDX_CH7_HIGH   10'h12F
`define ARB_IDX_CH8_LOW    10'h130
`define ARB_IDX_CH8_HIGH   10'h131
`define ARB_IDX_IRQ_STATUS 10'h140
`define ARB_IDX_IRQ_MASK   10'h141
`define ARB_IDX_FLAG_VIEW  10'h142

// Channel numbering and slot selection.
`define ARB_FIRST_CHANNEL  4'h3
`define ARB_SLOT_CH3       3'h0
`define ARB_SLOT_CH4       3'h1
`define ARB_SLOT_CH5       3'h2
`define ARB_SLOT_CH6       3'h3
`define ARB_SLOT_CH7       3'h4
`define ARB_SLOT_CH8       3'h5

// Field layout of the result byte pair.
`define ARB_HIGH_RES_MSB   9
`define ARB_HIGH_RES_LSB   2
`define ARB_LOW_RES_MSB    1
`define ARB_LOW_ONES       5'h1F

// Reset values.
`define ARB_RESULT_RST     10'h000
`define ARB_FLAG_RST       1'b0
`define ARB_STATUS_RST     6'h00
`define ARB_MASK_RST       6'h00
`define ARB_READDATA_RST   32'h0000_0000
`define ARB_WAIT_RST       1'b1

`endif

/* File: verilog/arb_result_slot.v */
// One channel's result byte pair with its result-stored flag.
// Assumes store and read_clear are single-cycle pulses on the same clock.
`timescale 1ns/1ps
`include "arb_result_bank_map.vh"

module arb_result_slot (
  // Clock and reset.
  input  wire       clock,
  input  wire       reset_n,
  // Conversion side.
  input  wire       store,
  input  wire [9:0] result,
  // Bus side.
  input  wire       read_clear,
  output wire [7:0] high_byte,
  output wire [7:0] low_byte,
  output wire       flag
);

  reg [9:0] result_reg;
  reg       flag_reg;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      result_reg <= `ARB_RESULT_RST;
      flag_reg   <= `ARB_FLAG_RST;
    end else begin
      if (store) begin
        result_reg <= result;
      end
      // A store in the cycle of a read keeps the flag set, so no result
      // arrives unannounced.
      if (store) begin
        flag_reg <= 1'b1;
      end else if (read_clear) begin
        flag_reg <= 1'b0;
      end
    end
  end

  assign high_byte =
    result_reg[`ARB_HIGH_RES_MSB:`ARB_HIGH_RES_LSB];
  assign low_byte  = {result_reg[`ARB_LOW_RES_MSB:0],
                      `ARB_LOW_ONES,
                      flag_reg};
  assign flag      = flag_reg;

endmodule

/* File: verilog/arb_avalon_slave.v */
// Avalon-MM handshake: every request is answered after one wait state.
// Assumes the master holds read or write until it sees waitrequest low.
`timescale 1ns/1ps
`include "arb_result_bank_map.vh"

module arb_avalon_slave (
  // Clock and reset.
  input  wire clock,
  input  wire reset_n,
  // Request strobes.
  input  wire avs_read,
  input  wire avs_write,
  // Handshake.
  output wire avs_waitrequest,
  output wire capture
);

  reg  wait_reg;
  wire request;

  assign request = avs_read | avs_write;

  // Capture marks the first cycle of a request; side effects happen there
  // once, even though the master holds the request for a second cycle.
  assign capture = request & wait_reg;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wait_reg <= `ARB_WAIT_RST;
    end else begin
      wait_reg <= ~capture;
    end
  end

  assign avs_waitrequest = wait_reg;

endmodule

/* File: verilog/arb_result_bank.v */
// Result register bank of a 10-bit converter, channels 3 to 8, behind an
// Avalon-MM slave with one wait state, plus a masked interrupt.
// Assumes conversion results arrive as one-cycle pulses on this clock.
//
// Behaviour
// - Result bits 9 to 2 sit in the high byte at bits 7 to 0.
// - Result bits 1 and 0 sit in the low byte at bits 7 and 6.
// - Bits 5 to 1 of every low byte always read as one.
// - Bit 0 of every low byte is a result-stored flag, 0 at reset.
// - Storing a new result sets that channel's flag in the same update.
// - Reading either byte of a channel clears that channel's flag, unless a store to it lands in the same cycle.
// - Each channel holds a ten-bit result, 1024 steps of the span.
`timescale 1ns/1ps
`include "arb_result_bank_map.vh"

module arb_result_bank #(
  parameter NUM_CH = 6
) (
  // Clock and reset.
  input  wire        clock,
  input  wire        reset_n,
  // Avalon-MM slave, byte addressed.
  input  wire [11:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Conversion results.
  input  wire        conv_valid,
  input  wire [3:0]  conv_channel,
  input  wire [9:0]  conv_result,
  // Interrupt.
  output wire        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  wire                capture;
  wire                aligned;
  wire [9:0]          word_index;
  wire                rd_capture;
  wire                wr_capture;

  reg                 sel_result;
  reg                 sel_high;
  reg  [2:0]          sel_slot;
  reg                 sel_status;
  reg                 sel_mask;
  reg                 sel_view;

  wire [NUM_CH-1:0]   store;
  wire [NUM_CH-1:0]   read_clear;
  wire [NUM_CH-1:0]   flags;
  wire [8*NUM_CH-1:0] high_bus;
  wire [8*NUM_CH-1:0] low_bus;

  reg  [NUM_CH-1:0]   status_reg;
  reg  [NUM_CH-1:0]   status_next;
  reg  [NUM_CH-1:0]   mask_reg;
  reg  [NUM_CH-1:0]   mask_next;
  reg                 irq_reg;
  reg  [31:0]         readdata_reg;
  reg  [31:0]         readdata_next;
  reg  [7:0]          byte_sel;

  integer             i;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake.

  arb_avalon_slave u_slave (
    .clock           (clock),
    .reset_n         (reset_n),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_waitrequest (avs_waitrequest),
    .capture         (capture)
  );

  assign rd_capture = capture & avs_read;
  assign wr_capture = capture & avs_write;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode. Only word-aligned byte addresses hit a register; any
  // other address reads as zero and ignores writes.

  assign aligned    = (avs_address[1:0] == 2'h0);
  assign word_index = avs_address[11:2];

  always @* begin
    sel_result = 1'b0;
    sel_high   = 1'b0;
    sel_slot   = `ARB_SLOT_CH3;
    sel_status = 1'b0;
    sel_mask   = 1'b0;
    sel_view   = 1'b0;
    if (aligned) begin
      case (word_index)
        `ARB_IDX_CH3_LOW: begin
          sel_result = 1'b1;
          sel_slot   = `ARB_SLOT_CH3;
        end
        `ARB_IDX_CH3_HIGH: begin
          sel_result = 1'b1;
          sel_high   = 1'b1;
          sel_slot   = `ARB_SLOT_CH3;
        end
        `ARB_IDX_CH4_LOW: begin
          sel_result = 1'b1;
          sel_slot   = `ARB_SLOT_CH4;
        end
        `ARB_IDX_CH4_HIGH: begin
          sel_result = 1'b1;
          sel_high   = 1'b1;
          sel_slot   = `ARB_SLOT_CH4;
        end
        `ARB_IDX_CH5_LOW: begin
          sel_result = 1'b1;
          sel_slot   = `ARB_SLOT_CH5;
        end
        `ARB_IDX_CH5_HIGH: begin
          sel_result = 1'b1;
          sel_high   = 1'b1;
          sel_slot   = `ARB_SLOT_CH5;
        end
        `ARB_IDX_CH6_LOW: begin
          sel_result = 1'b1;
          sel_slot   = `ARB_SLOT_CH6;
        end
        `ARB_IDX_CH6_HIGH: begin
          sel_result = 1'b1;
          sel_high   = 1'b1;
          sel_slot   = `ARB_SLOT_CH6;
        end
        `ARB_IDX_CH7_LOW: begin
          sel_result = 1'b1;
          sel_slot   = `ARB_SLOT_CH7;
        end
        `ARB_IDX_CH7_HIGH: begin
          sel_result = 1'b1;
          sel_high   = 1'b1;
          sel_slot   = `ARB_SLOT_CH7;
        end
        `ARB_IDX_CH8_LOW: begin
          sel_result = 1'b1;
          sel_slot   = `ARB_SLOT_CH8;
        end
        `ARB_IDX_CH8_HIGH: begin
          sel_result = 1'b1;
          sel_high   = 1'b1;
          sel_slot   = `ARB_SLOT_CH8;
        end
        `ARB_IDX_IRQ_STATUS: begin
          sel_status = 1'b1;
        end
        `ARB_IDX_IRQ_MASK: begin
          sel_mask = 1'b1;
        end
        `ARB_IDX_FLAG_VIEW: begin
          sel_view = 1'b1;
        end
        default: begin
          sel_result = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel slots. A result for a channel outside 3 to 8 matches no slot
  // and is dropped.

  genvar k;
  generate
    for (k = 0; k < NUM_CH; k = k + 1) begin : g_slot
      // A genvar cannot be part-selected, so its value is held here.
      localparam [31:0] SLOT_K = k;
      assign store[k] = conv_valid &
        (conv_channel == (`ARB_FIRST_CHANNEL + SLOT_K[3:0]));
      // Either byte of the pair clears the flag; writes never do.
      assign read_clear[k] = rd_capture & sel_result &
        (sel_slot == SLOT_K[2:0]);

      arb_result_slot u_slot (
        .clock      (clock),
        .reset_n    (reset_n),
        .store      (store[k]),
        .result     (conv_result),
        .read_clear (read_clear[k]),
        .high_byte  (high_bus[8*k +: 8]),
        .low_byte   (low_bus[8*k +: 8]),
        .flag       (flags[k])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask. Each store sets a sticky status bit; a read
  // of the status register clears it, but a store in that same cycle wins.

  always @* begin
    status_next = status_reg;
    if (rd_capture && sel_status) begin
      status_next = {NUM_CH{1'b0}};
    end
    status_next = status_next | store;
  end

  // Only the mask takes writes. Result bytes carry no write path at all,
  // so a write there is acknowledged and has no effect.
  always @* begin
    mask_next = mask_reg;
    if (wr_capture && sel_mask && avs_byteenable[0]) begin
      mask_next = avs_writedata[NUM_CH-1:0];
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= `ARB_STATUS_RST;
      mask_reg   <= `ARB_MASK_RST;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      // Built from the next values so irq tracks the status register
      // without a cycle of lag.
      irq_reg    <= |(status_next & mask_next);
    end
  end

  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read data. Sampled at the capture edge, the same edge that clears the
  // flag, so the value returned is the one the clear acted on.

  always @* begin
    byte_sel = 8'h00;
    for (i = 0; i < NUM_CH; i = i + 1) begin
      if (sel_slot == i[2:0]) begin
        if (sel_high) begin
          byte_sel = high_bus[8*i +: 8];
        end else begin
          byte_sel = low_bus[8*i +: 8];
        end
      end
    end
  end

  always @* begin
    readdata_next = readdata_reg;
    if (rd_capture) begin
      readdata_next = 32'h0000_0000;
      if (sel_result) begin
        readdata_next[7:0] = byte_sel;
      end else if (sel_status) begin
        readdata_next[NUM_CH-1:0] = status_reg;
      end else if (sel_mask) begin
        readdata_next[NUM_CH-1:0] = mask_reg;
      end else if (sel_view) begin
        readdata_next[NUM_CH-1:0] = flags;
      end
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      readdata_reg <= `ARB_READDATA_RST;
    end else begin
      readdata_reg <= readdata_next;
    end
  end

  assign avs_readdata = readdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Writes to result bytes, status, flag view or unmapped addresses fall
  // through every path above untouched.

endmodule

/* File: test/arb_result_bank_asserts.sv */
// Checker for the result register bank, bound to its top module.
// Assumes the master holds each request until waitrequest is low.
`timescale 1ns/1ps
module arb_result_bank_checker #(
  parameter NUM_CH = 6
) (
  input wire        clock,
  input wire        reset_n,
  input wire [11:0] avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        conv_valid,
  input wire [3:0]  conv_channel,
  input wire [9:0]  conv_result
);
  wire [9:0]  idx = avs_address[11:2];
  wire [9:0]  off = idx - 10'h120;
  wire        hit = avs_address[1:0] == 2'h0 && idx >= 10'h126
                    && idx <= 10'h131;
  wire        take = (avs_read || avs_write) && avs_waitrequest;
  wire        done = avs_read && !avs_waitrequest;
  wire        store = conv_valid && conv_channel >= 4'h3
                      && conv_channel <= 4'h8;
  reg  [9:0]  res_sh [0:15];
  reg  [15:0] flg_sh;
  reg  [9:0]  res_q;
  reg         flg_q;
  reg         lo_q;
  reg         hi_q;
  integer     i;
  // A read returns the value held before its own clear; a store wins.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < 16; i = i + 1)
        res_sh[i] <= 10'h000;
      flg_sh <= 16'h0000;
      res_q <= 10'h000;
      flg_q <= 1'b0;
      lo_q <= 1'b0;
      hi_q <= 1'b0;
    end else begin
      if (take) begin
        lo_q <= avs_read && hit && !idx[0];
        hi_q <= avs_read && hit && idx[0];
        res_q <= res_sh[off[4:1]];
        flg_q <= flg_sh[off[4:1]];
      end
      if (take && avs_read && hit)
        flg_sh[off[4:1]] <= 1'b0;
      if (store) begin
        res_sh[conv_channel] <= conv_result;
        flg_sh[conv_channel] <= 1'b1;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_hi_bits; done && hi_q |-> avs_readdata[7:0] == res_q[9:2];
  endproperty
  a_hi_bits: assert property (p_hi_bits)
    else $error("high byte differs from stored result");
  property p_lo_bits; done && lo_q |-> avs_readdata[7:6] == res_q[1:0];
  endproperty
  a_lo_bits: assert property (p_lo_bits)
    else $error("low byte result bits differ");
  property p_ones; done && lo_q |-> avs_readdata[5:1] == 5'h1F; endproperty
  a_ones: assert property (p_ones)
    else $error("low byte constant bits not all one");
  property p_flag_clr; done && lo_q && !flg_q |-> !avs_readdata[0];
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("flag reads one but should be clear");
  property p_flag_set; done && lo_q && flg_q |-> avs_readdata[0]; endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag reads zero after a store");
  property p_upper; done && (lo_q || hi_q) |-> avs_readdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper)
    else $error("result word has upper bits set");
  property p_wr_ack; avs_write && avs_waitrequest |=> !avs_waitrequest
    ##1 avs_waitrequest; endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("write not answered after one wait state");
  property p_rd_ack; avs_read && avs_waitrequest |=> !avs_waitrequest
    ##1 avs_waitrequest; endproperty
  a_rd_ack: assert property (p_rd_ack)
    else $error("read not answered after one wait state");
  c_store: cover property (store);
  c_flag_read: cover property (done && lo_q && flg_q);
  c_write: cover property (avs_write && avs_waitrequest && hit);
endmodule
bind arb_result_bank arb_result_bank_checker #(.NUM_CH(NUM_CH)) u_chk (
  .clock(clock), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .conv_valid(conv_valid), .conv_channel(conv_channel),
  .conv_result(conv_result));

/* File: test/arb_result_bank_tb_top.sv */
// Self-checking bench for the result register bank.
// Drives the bus and conversion ports itself; expectations come from a model.
`timescale 1ns/1ps
module arb_result_bank_tb_top;
  logic        clock, reset_n, avs_read, avs_write, conv_valid;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [3:0]  avs_byteenable, conv_channel;
  logic [9:0]  conv_result, r, e_res [0:15];
  logic        avs_waitrequest, irq;
  logic [15:0] e_flg;
  logic [5:0]  e_stat, e_mask;
  integer      n_mismatch, n_compared, k, c;
  arb_result_bank dut (.clock(clock), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .conv_valid(conv_valid), .conv_channel(conv_channel),
    .conv_result(conv_result), .irq(irq));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task check(input string nm, input [31:0] seen, input [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic in_bank(input [11:0] a);
    in_bank = a[1:0] == 2'h0 && a[11:2] >= 10'h126 && a[11:2] <= 10'h131;
  endfunction
  function automatic [31:0] exp_val(input [11:0] a);
    logic [9:0] o;
    o = (a[11:2] - 10'h120) >> 1;
    exp_val = 32'h0;
    if (in_bank(a))
      exp_val = a[2] ? {24'h0, e_res[o][9:2]}
                     : {24'h0, e_res[o][1:0], 5'h1F, e_flg[o]};
    else if (a == 12'h500) exp_val = {26'h0, e_stat};
    else if (a == 12'h504) exp_val = {26'h0, e_mask};
  endfunction
  // Every transfer ends one idle edge later so no strobe is driven twice
  // in one time step.
  task bus(input logic wr, input [11:0] a, input [31:0] wd);
    integer n;
    n = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) begin
      n = n + 1;
      if (n > 16) begin
        n_mismatch = n_mismatch + 1;
        report_and_stop;
      end
      @(posedge clock);
    end
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
    if (wr && a == 12'h504) e_mask = wd[5:0];
  endtask
  task rd_check(input [11:0] a);
    bus(1'b0, a, 32'h0);
    check("readdata", d, exp_val(a));
    if (in_bank(a)) e_flg[(a[11:2] - 10'h120) >> 1] = 1'b0;
    if (a == 12'h500) e_stat = 6'h00;
  endtask
  task store(input [3:0] ch, input [9:0] v);
    conv_valid <= 1'b1;
    conv_channel <= ch;
    conv_result <= v;
    @(posedge clock);
    conv_valid <= 1'b0;
    if (ch >= 4'h3 && ch <= 4'h8) begin
      e_res[ch] = v;
      e_flg[ch] = 1'b1;
      e_stat[ch - 4'h3] = 1'b1;
    end
    @(posedge clock);
  endtask
  task irq_is(input logic e);
    @(negedge clock);
    check("irq", {31'h0, irq}, {31'h0, e});
    @(posedge clock);
  endtask
  task do_reset;
    reset_n <= 1'b0;
    repeat (10) @(posedge clock);
    check("waitrequest", {31'h0, avs_waitrequest}, 32'h1);
    check("readdata", avs_readdata, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
    for (k = 0; k < 16; k = k + 1) e_res[k] = 10'h000;
    {e_flg, e_stat, e_mask} = 28'h0;
    reset_n <= 1'b1;
    @(posedge clock);
    for (k = 12'h498; k <= 12'h4C4; k = k + 4) rd_check(k);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {avs_read, avs_write, conv_valid, avs_address} = 15'h0;
    {avs_writedata, conv_channel, conv_result} = 46'h0;
    avs_byteenable = 4'hF;
    {n_mismatch, n_compared} = 0;
    void'($urandom(65));
    do_reset;
    for (k = 0; k < 30; k = k + 1) begin
      c = 3 + $urandom % 6;
      r = (k % 5 == 0) ? 10'h3FF : (k % 5 == 1) ? 10'h000 : $urandom;
      store(c, r);
      rd_check(12'h480 + c * 8 + ($urandom % 2) * 4);
      rd_check(12'h480 + c * 8);
    end
    store(4'h2, 10'h155);
    store(4'h9, 10'h2AA);
    for (c = 3; c <= 8; c = c + 1) store(c, $urandom);
    for (k = 12'h498; k <= 12'h4C4; k = k + 4) bus(1'b1, k, 32'hFFFFFFFF);
    for (k = 12'h498; k <= 12'h4C4; k = k + 4) rd_check(k);
    rd_check(12'h500);
    bus(1'b1, 12'h504, 32'h4);
    rd_check(12'h504);
    store(4'h4, 10'h123);
    irq_is(1'b0);
    store(4'h5, 10'h321);
    irq_is(1'b1);
    rd_check(12'h500);
    irq_is(1'b0);
    rd_check(12'h7FC);
    rd_check(12'h49A);
    store(4'h6, 10'h0F0);
    do_reset;
    report_and_stop;
  end
endmodule
